// *** design/tss_map.vh ***
`ifndef TSS_MAP_VH
`define TSS_MAP_VH
// Time code length in bits
`define TSS_CODE_BITS 48
`define TSS_CODE_CW 6
// Output bit clock half period in sys_clk cycles (20 MHz / 8 = 2.5 MHz bit clock)
`define TSS_HALF_PERIOD 8'h04
// Idle bit clock rising edges counted before next heartbeat; a code is followed by one idle period more than this
`define TSS_GAP_BITS 8'h10
`define TSS_ZERO_CODE 48'h000000000000
`endif

// *** design/tss_sync2.v ***
`default_nettype none
module tss_sync2 (
	input wire sys_clk,
	input wire rst_n,
	input wire [2:0] asyncIn,
	output reg [2:0] syncOut
);
reg [2:0] meta_q;
always @(posedge sys_clk) begin
	if (!rst_n) begin
		meta_q <= 3'h0;
		syncOut <= 3'h0;
	end else begin
		meta_q <= asyncIn;
		syncOut <= meta_q;
	end
end
endmodule
`default_nettype wire

// *** design/tss_port.v ***
// Functional notes
// (RQ1) Three two-way lines: heartbeat, bit clock, time code, turned together.
// (RQ2) As timing master all lines are inputs; timing taken from outside.
// (RQ3) As timing slave the block drives bit clock, heartbeat and time code.
// (RQ4) In input mode outside hardware makes clocks and shifts one code per beat.
// (RQ5) Each code stands for the time of the latest heartbeat rising edge.
// (RQ6) In input mode heartbeat and code are sampled on bit clock falling edges.
// (RQ7) Heartbeat starts each code transfer; bit clock paces its bits.
// (RQ8) In output mode heartbeat and code change on bit clock rising edges.
`include "tss_map.vh"
`default_nettype none
module tss_port (
	input wire sys_clk,
	input wire rst_n,
	input wire masterMode,
	input wire [47:0] localTime,
	input wire heartbeatPulseIn,
	input wire timeBitClockIn,
	input wire serialTimeCodeIn,
	output reg heartbeatPulseOut,
	output reg timeBitClockOut,
	output reg serialTimeCodeOut,
	output reg portOe,
	output reg [47:0] rxTime,
	output reg rxValid,
	output reg [47:0] beatTime,
	output reg beatStrobe
);
////////////////////////////////////////////////////////////////////////////////
// Input synchronisers
wire [2:0] pinSync;
tss_sync2 uSync (
	.sys_clk(sys_clk),
	.rst_n(rst_n),
	.asyncIn({heartbeatPulseIn, timeBitClockIn, serialTimeCodeIn}),
	.syncOut(pinSync)
);
reg [2:0] pinPrev_q;
always @(posedge sys_clk) begin
	if (!rst_n)
		pinPrev_q <= 3'h0;
	else
		pinPrev_q <= pinSync;
end
wire clkFall = pinPrev_q[1] & ~pinSync[1];
wire hbSample = pinSync[2];
wire codeSample = pinSync[0];
////////////////////////////////////////////////////////////////////////////////
// Direction
always @(posedge sys_clk) begin
	if (!rst_n)
		portOe <= 1'b0;
	else
		// (RQ1) (RQ2) (RQ3) Common line direction
		portOe <= ~masterMode;
end
////////////////////////////////////////////////////////////////////////////////
// Receiver
// Shift one bit in at the bottom
function [47:0] shiftIn;
	input [47:0] word;
	input bitIn;
	begin
		shiftIn = {word[46:0], bitIn};
	end
endfunction
reg hbLast_q;
reg hbLast_d;
reg busy_q;
reg busy_d;
reg [5:0] rxCnt_q;
reg [5:0] rxCnt_d;
reg [47:0] rxShift_q;
reg [47:0] rxShift_d;
reg [47:0] rxTime_d;
reg rxValid_d;
always @* begin
	hbLast_d = hbLast_q;
	busy_d = busy_q;
	rxCnt_d = rxCnt_q;
	rxShift_d = rxShift_q;
	rxTime_d = rxTime;
	rxValid_d = 1'b0;
	// (RQ6) Falling edge sampling
	if (masterMode && clkFall) begin
		hbLast_d = hbSample;
		// (RQ7) (RQ4) Heartbeat starts code
		if (hbSample && !hbLast_q) begin
			busy_d = 1'b1;
			rxCnt_d = 6'h00;
		end else if (busy_q) begin
			rxShift_d = shiftIn(rxShift_q, codeSample);
			if (rxCnt_q == `TSS_CODE_BITS - 1) begin
				busy_d = 1'b0;
				rxValid_d = 1'b1;
				// (RQ5) Code marks beat edge time
				rxTime_d = shiftIn(rxShift_q, codeSample);
			end else begin
				rxCnt_d = rxCnt_q + 6'h01;
			end
		end
	end else if (!masterMode) begin
		// (RQ3) Receiver idle while driving
		busy_d = 1'b0;
	end
end
always @(posedge sys_clk) begin
	if (!rst_n) begin
		hbLast_q <= 1'b0;
		busy_q <= 1'b0;
		rxCnt_q <= 6'h00;
		rxShift_q <= `TSS_ZERO_CODE;
		rxTime <= `TSS_ZERO_CODE;
		rxValid <= 1'b0;
	end else begin
		hbLast_q <= hbLast_d;
		busy_q <= busy_d;
		rxCnt_q <= rxCnt_d;
		rxShift_q <= rxShift_d;
		rxTime <= rxTime_d;
		rxValid <= rxValid_d;
	end
end
////////////////////////////////////////////////////////////////////////////////
// Transmitter
localparam ST_IDLE = 3'h1;
localparam ST_BEAT = 3'h2;
localparam ST_DATA = 3'h4;
reg [2:0] st_q;
reg [2:0] st_d;
reg [7:0] div_q;
reg [7:0] div_d;
reg [7:0] bitCnt_q;
reg [7:0] bitCnt_d;
reg [47:0] txShift_q;
reg [47:0] txShift_d;
reg bitClock_d;
reg heartbeat_d;
reg code_d;
reg [47:0] beatTime_d;
reg beatStrobe_d;
wire tick = (div_q == `TSS_HALF_PERIOD - 8'h01);
wire rise = tick & ~timeBitClockOut;
always @* begin
	st_d = st_q;
	div_d = tick ? 8'h00 : div_q + 8'h01;
	bitCnt_d = bitCnt_q;
	txShift_d = txShift_q;
	bitClock_d = tick ? ~timeBitClockOut : timeBitClockOut;
	heartbeat_d = heartbeatPulseOut;
	code_d = serialTimeCodeOut;
	beatTime_d = beatTime;
	beatStrobe_d = 1'b0;
	// (RQ8) Lines change on rising edge
	if (rise) begin
		case (st_q)
			ST_IDLE: begin
				heartbeat_d = 1'b0;
				code_d = 1'b0;
				if (bitCnt_q == `TSS_GAP_BITS) begin
					st_d = ST_BEAT;
					bitCnt_d = 8'h00;
					heartbeat_d = 1'b1;
					// (RQ5) Capture time of beat edge
					txShift_d = localTime;
					beatTime_d = localTime;
					beatStrobe_d = 1'b1;
				end else begin
					bitCnt_d = bitCnt_q + 8'h01;
				end
			end
			ST_BEAT: begin
				// (RQ7) Code follows heartbeat
				heartbeat_d = 1'b0;
				code_d = txShift_q[47];
				txShift_d = shiftIn(txShift_q, 1'b0);
				bitCnt_d = 8'h01;
				st_d = ST_DATA;
			end
			ST_DATA: begin
				if (bitCnt_q == `TSS_CODE_BITS) begin
					code_d = 1'b0;
					bitCnt_d = 8'h00;
					st_d = ST_IDLE;
				end else begin
					code_d = txShift_q[47];
					txShift_d = shiftIn(txShift_q, 1'b0);
					bitCnt_d = bitCnt_q + 8'h01;
				end
			end
			default: begin
				st_d = ST_IDLE;
			end
		endcase
	end
end
always @(posedge sys_clk) begin
	// (RQ2) Master mode holds transmitter idle
	if (!rst_n || masterMode) begin
		st_q <= ST_IDLE;
		div_q <= 8'h00;
		bitCnt_q <= 8'h00;
		txShift_q <= `TSS_ZERO_CODE;
		timeBitClockOut <= 1'b0;
		heartbeatPulseOut <= 1'b0;
		serialTimeCodeOut <= 1'b0;
		beatTime <= `TSS_ZERO_CODE;
		beatStrobe <= 1'b0;
	end else begin
		st_q <= st_d;
		div_q <= div_d;
		bitCnt_q <= bitCnt_d;
		txShift_q <= txShift_d;
		timeBitClockOut <= bitClock_d;
		heartbeatPulseOut <= heartbeat_d;
		serialTimeCodeOut <= code_d;
		beatTime <= beatTime_d;
		beatStrobe <= beatStrobe_d;
	end
end
endmodule
`default_nettype wire

// *** verif/tss_port_props.sv ***
`default_nettype none
module tss_port_props (
	input wire logic sys_clk, rst_n, masterMode, portOe, rxValid, beatStrobe,
	input wire logic timeBitClockOut, heartbeatPulseOut, serialTimeCodeOut,
	input wire logic [47:0] rxTime
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	sequence hb8; heartbeatPulseOut[*8] ##1 !heartbeatPulseOut; endsequence
	chk_oe_follow: assert property (
		$past(rst_n) |-> portOe == !$past(masterMode)) else $error("oe");
	chk_master_quiet: assert property (
		masterMode |=> !timeBitClockOut && !heartbeatPulseOut) else $error("quiet");
	chk_clk_half: assert property (
		$rose(timeBitClockOut) |-> timeBitClockOut[*4] ##1 !timeBitClockOut) else $error("clk");
	chk_strobe_beat: assert property (
		$rose(heartbeatPulseOut) |-> beatStrobe) else $error("strobe");
	chk_hb_width: assert property (
		$rose(heartbeatPulseOut) |-> hb8) else $error("width");
	chk_code_edge: assert property (
		$changed({heartbeatPulseOut, serialTimeCodeOut}) && !$past(masterMode)
		|-> timeBitClockOut) else $error("edge");
	chk_rx_pulse: assert property (
		$changed(rxTime) |-> rxValid ##1 !rxValid) else $error("rx");
endmodule
bind tss_port tss_port_props u_chk (.*);
`default_nettype wire

// *** verif/tss_far_end.sv ***
`default_nettype none
module tss_far_end;
	timeunit 1ns;
	timeprecision 1ns;
	logic hb = 0, bclk = 0, dat = 0;
	task send(input logic [47:0] c, input int n);
		for (int i = -1; i < n; i++) begin
			#200 bclk = 1;
			hb = i < 0;
			dat = i < 0 ? ~dat : c[47-i];
			#200 bclk = 0;
		end
		#200 dat = ~dat;
	endtask
endmodule
`default_nettype wire

// *** verif/tb_tss_port.sv ***
`default_nettype none
module tb_tss_port;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk = 0, rst_n = 0, mm = 1;
	logic [47:0] lt = 48'h0, exp, got, prv;
	logic [31:0] rng = 32'hba47;
	wire logic [47:0] rxT, bT;
	wire logic hbO, bcO, tcO, oe, rxV, bS;
	int errCount = 0, nTests = 0, cyc = 0;
	logic [47:0] q[$];
	tss_far_end far ();
	tss_port u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .masterMode(mm), .localTime(lt),
		.heartbeatPulseIn(oe ? hbO : far.hb), .timeBitClockIn(oe ? bcO : far.bclk),
		.serialTimeCodeIn(oe ? tcO : far.dat), .heartbeatPulseOut(hbO),
		.timeBitClockOut(bcO), .serialTimeCodeOut(tcO), .portOe(oe), .rxTime(rxT),
		.rxValid(rxV), .beatTime(bT), .beatStrobe(bS));
	function logic [47:0] rnd();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return {rng[15:0], rng};
	endfunction
	task chk(input logic [47:0] g, input logic [47:0] e);
		nTests++;
		if (g !== e) begin
			errCount++;
			$display("BAD %0t %h %h", $time, g, e);
		end
	endtask
	task finish_test();
		$display("errors %0d checks %0d", errCount, nTests);
		if (errCount == 0 && nTests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial forever #25 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 8000) begin
			errCount++;
			finish_test();
		end
		if (rxV && !oe) chk(rxT, q.pop_front());
	end
	initial begin
		repeat (16) @(posedge sys_clk);
		rst_n <= 1;
		// Full, short then full code in
		for (int i = 0; i < 3; i++) begin
			got = rnd();
			if (i != 1) q.push_back(got);
			far.send(got, i == 1 ? 20 : 48);
		end
		#2000 chk(q.size(), 0);
		got = rnd();
		@(posedge sys_clk) begin
			mm <= 0;
			lt <= got;
		end
		repeat (2) begin
			@(posedge bS) #1 chk(bT, got);
			prv = got;
			got = rnd();
			@(posedge sys_clk) lt <= got;
			@(negedge bcO) chk(hbO, 1);
			repeat (48) @(negedge bcO) exp = {exp[46:0], tcO};
			chk(exp, prv);
		end
		finish_test();
	end
endmodule
`default_nettype wire
